/* rtl/ais_params.svh */
// Offsets, field positions, reset values and timing counts for analog input scaling
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH

// Object entry indices (object index, subindex)
`define AIS_OBJ_READING 16'h3320
`define AIS_OBJ_OFFSET 16'h3321
`define AIS_OBJ_MULT 16'h3322
`define AIS_OBJ_DENOM 16'h3323
`define AIS_SUB_COUNT 8'h00
`define AIS_SUB_IN1 8'h01
`define AIS_SUB_IN2 8'h02

// Reset values
`define AIS_CHAN_COUNT 8'h02
`define AIS_OFFSET_RST 16'h0000
`define AIS_MULT_RST 16'h0001
`define AIS_DENOM_RST 16'h0001
`define AIS_READING_RST 32'h0000_0000

// Divider timing: one step per clock, one step per quotient bit
`define AIS_DIV_STEPS 6'h22

`endif

/* rtl/ais_pkg.sv */
// Types shared by the analog input scaling design
package ais_pkg;

    // Divider sequencer states, one-hot
    typedef enum logic [2:0]
    {
        AIS_DIV_IDLE = 3'b001,
        AIS_DIV_RUN = 3'b010,
        AIS_DIV_DONE = 3'b100
    } ais_div_state_t;

endpackage : ais_pkg

/* rtl/ais_divider.sv */
// Sequential signed divider, truncating toward zero
`timescale 1ns/10ps
`include "ais_params.svh"

module ais_divider
    import ais_pkg::*;
#(
    parameter int NUM_W = 34
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Request
    input wire logic start,
    input wire logic signed [NUM_W-1:0] dividend,
    input wire logic signed [15:0] divisor,
    // Answer
    output logic busy,
    output logic done,
    output logic signed [31:0] quotient
);

    // Magnitudes and signs latched at start
    logic [NUM_W-1:0] rem_reg;
    logic [NUM_W-1:0] quo_reg;
    logic [15:0] dvs_reg;
    logic neg_reg;
    logic [5:0] cnt_reg;
    ais_div_state_t state_reg;
    logic [NUM_W:0] trial;
    logic [NUM_W-1:0] shifted;
    logic [NUM_W-1:0] q_last; // Magnitude including the final quotient bit

    // ------------------------------------------------------------------
    // Restoring division step
    // ------------------------------------------------------------------
    // Shift in the next dividend bit, subtract if it fits
    always_comb
    begin
        shifted = {rem_reg[NUM_W-2:0], quo_reg[NUM_W-1]};
        trial = {1'b0, shifted} - {{(NUM_W-15){1'b0}}, dvs_reg};
        q_last = {quo_reg[NUM_W-2:0], !trial[NUM_W]};
    end

    // Sequencer and datapath
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_reg <= AIS_DIV_IDLE;
            rem_reg <= '0;
            quo_reg <= '0;
            dvs_reg <= 16'h0001;
            neg_reg <= 1'b0;
            cnt_reg <= 6'h00;
            quotient <= `AIS_READING_RST;
        end
        else
        begin
            case (state_reg)
                AIS_DIV_IDLE:
                begin
                    if (start)
                    begin
                        // Work on magnitudes; sign fixed at the end for truncation to zero
                        rem_reg <= '0;
                        quo_reg <= dividend[NUM_W-1] ? NUM_W'(-dividend) : dividend;
                        dvs_reg <= divisor[15] ? 16'(-divisor) : divisor;
                        neg_reg <= dividend[NUM_W-1] ^ divisor[15];
                        cnt_reg <= 6'(NUM_W);
                        state_reg <= AIS_DIV_RUN;
                    end
                end
                AIS_DIV_RUN:
                begin
                    if (trial[NUM_W])
                    begin
                        rem_reg <= shifted;
                        quo_reg <= {quo_reg[NUM_W-2:0], 1'b0};
                    end
                    else
                    begin
                        rem_reg <= trial[NUM_W-1:0];
                        quo_reg <= {quo_reg[NUM_W-2:0], 1'b1};
                    end
                    cnt_reg <= cnt_reg - 6'h01;
                    // Quotient lands with the last bit, so done sees it settled
                    if (cnt_reg == 6'h01)
                    begin
                        // Results beyond 32 bits wrap; sign applied last
                        quotient <= neg_reg ? 32'(-q_last) : q_last[31:0];
                        state_reg <= AIS_DIV_DONE;
                    end
                end
                AIS_DIV_DONE:
                begin
                    state_reg <= AIS_DIV_IDLE;
                end
                default:
                    state_reg <= AIS_DIV_IDLE;
            endcase
        end
    end

    // Handshake outputs
    assign busy = (state_reg != AIS_DIV_IDLE);
    assign done = (state_reg == AIS_DIV_DONE);

endmodule : ais_divider

/* rtl/ais_scaler.sv */
// Analog input scaling: offset, numerator, denominator, published readings
`timescale 1ns/10ps
`include "ais_params.svh"

module ais_scaler
    import ais_pkg::*;
#(
    parameter int RAW_W = 16,
    parameter bit IN2_PRESENT = 1'b1
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Raw converter samples, same clock domain
    input wire logic [RAW_W-1:0] raw_in1,
    input wire logic [RAW_W-1:0] raw_in2,
    input wire logic raw_valid,
    // Object dictionary access
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [31:0] obj_wdata,
    output logic [31:0] obj_rdata,
    output logic obj_ack,
    output logic obj_err,
    // Published readings for process data
    output logic signed [31:0] scaled_reading_in1,
    output logic signed [31:0] scaled_reading_in2
);

    localparam int NUM_W = 34; // 18-bit sum times 16-bit factor

    // ------------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------------
    logic signed [15:0] input_offset_in1_reg;
    logic signed [15:0] input_offset_in2_reg;
    logic signed [15:0] multiplier_in1_reg;
    logic signed [15:0] multiplier_in2_reg;
    logic signed [15:0] denom_in1_reg;
    logic signed [15:0] denom_in2_reg;
    logic in2_hit; // Entry belongs to input 2
    logic in1_hit; // Entry belongs to input 1
    logic known_obj; // One of the four objects
    logic known_sub; // Subindex exists on this variant

    // Entry decode; input 2 entries vanish without the input
    always_comb
    begin
        known_obj = (obj_index == `AIS_OBJ_READING) || (obj_index == `AIS_OBJ_OFFSET)
            || (obj_index == `AIS_OBJ_MULT) || (obj_index == `AIS_OBJ_DENOM);
        in1_hit = (obj_sub == `AIS_SUB_IN1);
        in2_hit = (obj_sub == `AIS_SUB_IN2) && IN2_PRESENT;
        known_sub = (obj_sub == `AIS_SUB_COUNT) || in1_hit || in2_hit;
    end

    // Setting writes; count and reading entries are read-only
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            input_offset_in1_reg <= `AIS_OFFSET_RST;
            input_offset_in2_reg <= `AIS_OFFSET_RST;
            multiplier_in1_reg <= `AIS_MULT_RST;
            multiplier_in2_reg <= `AIS_MULT_RST;
            denom_in1_reg <= `AIS_DENOM_RST;
            denom_in2_reg <= `AIS_DENOM_RST;
        end
        else if (obj_wr && known_obj)
        begin
            // Offset entries
            if (obj_index == `AIS_OBJ_OFFSET && in1_hit)
                input_offset_in1_reg <= obj_wdata[15:0];
            if (obj_index == `AIS_OBJ_OFFSET && in2_hit)
                input_offset_in2_reg <= obj_wdata[15:0];
            // Numerator entries
            if (obj_index == `AIS_OBJ_MULT && in1_hit)
                multiplier_in1_reg <= obj_wdata[15:0];
            if (obj_index == `AIS_OBJ_MULT && in2_hit)
                multiplier_in2_reg <= obj_wdata[15:0];
            // Denominator entries
            if (obj_index == `AIS_OBJ_DENOM && in1_hit)
                denom_in1_reg <= obj_wdata[15:0];
            if (obj_index == `AIS_OBJ_DENOM && in2_hit)
                denom_in2_reg <= obj_wdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Sample capture and arithmetic front end
    // ------------------------------------------------------------------
    // Raw counts held until the next sample replaces them
    logic [RAW_W-1:0] raw1_reg;
    logic [RAW_W-1:0] raw2_reg;
    logic pend1_reg; // Fresh sample for input 1 awaiting divide
    logic pend2_reg; // Fresh sample for input 2 awaiting divide
    logic chan_reg; // Channel now in the divider
    logic signed [17:0] sum; // Raw plus offset; full raw range plus sign
    logic signed [NUM_W-1:0] product; // Sum times numerator
    logic signed [15:0] sel_off;
    logic signed [15:0] sel_mul;
    logic signed [15:0] sel_den;
    logic [RAW_W-1:0] sel_raw;
    logic div_start;
    logic div_busy;
    logic div_done;
    logic signed [31:0] div_q;

    // Latch samples; a new sample overwrites one still waiting
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            raw1_reg <= '0;
            raw2_reg <= '0;
        end
        else if (raw_valid)
        begin
            raw1_reg <= raw_in1;
            raw2_reg <= raw_in2;
        end
    end

    // Pending flags; a new sample wins over the clear at launch
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            pend1_reg <= 1'b0;
            pend2_reg <= 1'b0;
        end
        else
        begin
            if (raw_valid)
                pend1_reg <= 1'b1;
            else if (div_start && !next_chan)
                pend1_reg <= 1'b0;
            if (raw_valid && IN2_PRESENT)
                pend2_reg <= 1'b1;
            else if (div_start && next_chan)
                pend2_reg <= 1'b0;
        end
    end

    // Channel selection: alternate so neither input starves
    logic next_chan;
    always_comb
    begin
        if (pend1_reg && pend2_reg)
            next_chan = !chan_reg;
        else
            next_chan = pend2_reg;
        div_start = !div_busy && (pend1_reg || pend2_reg);
    end

    // Remember which channel is in flight
    always_ff @(posedge core_clk)
    begin
        // Starts as if input 2 ran last, so input 1 goes first
        if (!rst_b)
            chan_reg <= 1'b1;
        else if (!div_busy && (pend1_reg || pend2_reg))
            chan_reg <= next_chan;
    end

    // Operand mux on the channel about to launch
    always_comb
    begin
        sel_raw = next_chan ? raw2_reg : raw1_reg;
        sel_off = next_chan ? input_offset_in2_reg : input_offset_in1_reg;
        sel_mul = next_chan ? multiplier_in2_reg : multiplier_in1_reg;
        sel_den = next_chan ? denom_in2_reg : denom_in1_reg;
        // Offset first, then numerator; widths rule out overflow
        sum = 18'($signed({2'b00, sel_raw[15:0]})) + 18'(sel_off);
        product = NUM_W'(sum) * NUM_W'(sel_mul);
    end

    // Launch only with a usable denominator
    logic launch;
    assign launch = div_start && (sel_den != 16'sh0000);

    // ------------------------------------------------------------------
    // Division and publication
    // ------------------------------------------------------------------
    ais_divider #(
        .NUM_W(NUM_W)
    ) u_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(launch),
        .dividend(product),
        .divisor(sel_den),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_q)
    );

    // Published readings update on divider completion only
    logic pub_chan_reg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            pub_chan_reg <= 1'b0;
        else if (launch)
            pub_chan_reg <= next_chan;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            scaled_reading_in1 <= `AIS_READING_RST;
            scaled_reading_in2 <= `AIS_READING_RST;
        end
        else if (div_done)
        begin
            // With unity settings the quotient equals the raw count
            if (!pub_chan_reg)
                scaled_reading_in1 <= 32'(div_q);
            else
                scaled_reading_in2 <= 32'(div_q);
        end
    end

    // ------------------------------------------------------------------
    // Object read port
    // ------------------------------------------------------------------
    // Registered answer one cycle after the request
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            obj_rdata <= 32'h0000_0000;
            obj_ack <= 1'b0;
            obj_err <= 1'b0;
        end
        else
        begin
            obj_ack <= (obj_rd || obj_wr) && known_obj && known_sub;
            obj_err <= (obj_rd || obj_wr) && !(known_obj && known_sub);
            obj_rdata <= 32'h0000_0000;
            if (obj_rd && known_obj)
            begin
                if (obj_sub == `AIS_SUB_COUNT)
                    obj_rdata <= {24'h000000, `AIS_CHAN_COUNT};
                else if (obj_index == `AIS_OBJ_READING)
                    obj_rdata <= in1_hit ? scaled_reading_in1
                        : (in2_hit ? scaled_reading_in2 : 32'h0000_0000);
                else if (obj_index == `AIS_OBJ_OFFSET)
                    obj_rdata <= in1_hit ? 32'(input_offset_in1_reg)
                        : (in2_hit ? 32'(input_offset_in2_reg) : 32'h0000_0000);
                else if (obj_index == `AIS_OBJ_MULT)
                    obj_rdata <= in1_hit ? 32'(multiplier_in1_reg)
                        : (in2_hit ? 32'(multiplier_in2_reg) : 32'h0000_0000);
                else
                    obj_rdata <= in1_hit ? 32'(denom_in1_reg)
                        : (in2_hit ? 32'(denom_in2_reg) : 32'h0000_0000);
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_count_fixed: assert property (@(posedge core_clk) disable iff (!rst_b)
        obj_rd && known_obj && obj_sub == `AIS_SUB_COUNT |=> obj_rdata == 32'h0000_0002)
        else $error("count entry not two");
    a_zero_denom: assert property (@(posedge core_clk) disable iff (!rst_b)
        div_start && sel_den == 16'sh0000 |=> !div_busy)
        else $error("division by zero launched");
    a_reading_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !div_done |=> $stable(scaled_reading_in1) && $stable(scaled_reading_in2))
        else $error("reading changed without result");
    a_div_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
        launch |-> ##[35:35] div_done)
        else $error("divider latency wrong");
    a_in2_absent: assert property (@(posedge core_clk) disable iff (!rst_b)
        !IN2_PRESENT |-> !pend2_reg && scaled_reading_in2 == 32'h0000_0000)
        else $error("absent input two active");
    a_offset_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
        obj_wr && obj_index == `AIS_OBJ_OFFSET && in1_hit
        |=> input_offset_in1_reg == $past(obj_wdata[15:0]))
        else $error("offset write lost");
    a_mult_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
        obj_wr && obj_index == `AIS_OBJ_MULT && in2_hit
        |=> multiplier_in2_reg == $past(obj_wdata[15:0]))
        else $error("multiplier write lost");
    a_unity_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
        launch && !next_chan && sel_off == 16'sh0000 && sel_mul == 16'sh0001
        && sel_den == 16'sh0001 |-> ##36 scaled_reading_in1 == 32'($past(raw1_reg, 36)))
        else $error("unity settings altered count");

endmodule : ais_scaler

/* tb/ais_master_model.sv */
// Fieldbus master model that reads and writes the scaling objects
`timescale 1ns/10ps
`include "ais_params.svh"

module ais_master_model
(
    // Clock
    input wire logic core_clk,
    // Object request
    output logic [15:0] obj_index,
    output logic [7:0] obj_sub,
    output logic obj_wr,
    output logic obj_rd,
    output logic [31:0] obj_wdata,
    // Object answer
    input wire logic [31:0] obj_rdata,
    input wire logic obj_ack,
    input wire logic obj_err
);
    // Set only by a scenario that loads a zero divisor on purpose
    bit allow_zero_den = 1'b0;

    // --------------------------------------------------------------
    // Idle bus at time zero
    // --------------------------------------------------------------
    initial
    begin
        obj_index = 16'h0000;
        obj_sub = 8'h00;
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_wdata = 32'h0000_0000;
    end

    // --------------------------------------------------------------
    // One object access: request held one cycle, answer one cycle later
    // --------------------------------------------------------------
    task access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                input logic [31:0] wdata, output logic [31:0] rdata,
                output logic ack, output logic err);
        // The master drops a zero divisor write unless allow_zero_den is set
        if (wr && idx == `AIS_OBJ_DENOM && wdata[15:0] == 16'h0000 && !allow_zero_den)
        begin
            rdata = 32'h0000_0000;
            ack = 1'b0;
            err = 1'b0;
        end
        else
        begin
            @(posedge core_clk);
            obj_index <= idx;
            obj_sub <= sub;
            obj_wdata <= wdata;
            obj_wr <= wr;
            obj_rd <= !wr;
            @(posedge core_clk);
            // Strobes drop; index, subindex and data show the inverse so stale values never pass
            obj_wr <= 1'b0;
            obj_rd <= 1'b0;
            obj_index <= ~idx;
            obj_sub <= ~sub;
            obj_wdata <= ~wdata;
            #1;
            rdata = obj_rdata;
            ack = obj_ack;
            err = obj_err;
        end
    endtask : access
endmodule : ais_master_model

/* tb/testbench.sv */
// Self-checking testbench for the analog input scaling block
`timescale 1ns/10ps
`include "ais_params.svh"

module testbench;
    // Row of an ordinary case: raw counts, settings, expected readings
    typedef struct {
        logic [15:0] raw1, raw2, off1, off2, num1, num2, den1, den2;
        logic [31:0] exp1, exp2;
    } ais_row_t;

    // Clock, reset and stimulus
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] raw_in1 = 16'h0000;
    logic [15:0] raw_in2 = 16'h0000;
    logic raw_valid = 1'b0;
    // Object bus; requests shared by both variants, answers kept separate
    logic [15:0] obj_index;
    logic [7:0] obj_sub;
    logic obj_wr, obj_rd;
    logic [31:0] obj_wdata, obj_rdata, rdata_b;
    logic obj_ack, obj_err, ack_b, err_b;
    // Readings of the two-input and one-input variants
    logic signed [31:0] in1_a, in2_a, in1_b, in2_b;
    // Counters and table
    int mismatches = 0;
    int num_checks = 0;
    ais_row_t rows [4];

    // --------------------------------------------------------------
    // Clock and watchdog
    // --------------------------------------------------------------
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end

    initial
    begin
        #200000;
        mismatches++;
        final_report();
    end

    // --------------------------------------------------------------
    // Devices and master
    // --------------------------------------------------------------
    ais_scaler #(.RAW_W(16), .IN2_PRESENT(1'b1)) ais_scaler_i (.core_clk(core_clk),
        .rst_b(rst_b), .raw_in1(raw_in1), .raw_in2(raw_in2), .raw_valid(raw_valid),
        .obj_index(obj_index), .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd),
        .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
        .scaled_reading_in1(in1_a), .scaled_reading_in2(in2_a));

    // Variant without the second input sees the same traffic
    ais_scaler #(.RAW_W(16), .IN2_PRESENT(1'b0)) ais_scaler_b_i (.core_clk(core_clk),
        .rst_b(rst_b), .raw_in1(raw_in1), .raw_in2(raw_in2), .raw_valid(raw_valid),
        .obj_index(obj_index), .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd),
        .obj_wdata(obj_wdata), .obj_rdata(rdata_b), .obj_ack(ack_b), .obj_err(err_b),
        .scaled_reading_in1(in1_b), .scaled_reading_in2(in2_b));

    ais_master_model ais_master_model_i (.core_clk(core_clk), .obj_index(obj_index),
        .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata),
        .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask : check

    // Read an entry and compare the answer; err_exp selects refusal
    task rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp,
            input logic err_exp);
        logic [31:0] d;
        logic a, e;
        ais_master_model_i.access(1'b0, idx, sub, 32'h0000_0000, d, a, e);
        check({31'h0, e}, {31'h0, err_exp});
        check({31'h0, a}, {31'h0, !err_exp});
        if (!err_exp)
            check(d, exp);
    endtask : rd

    // Write a 16-bit setting and expect an acknowledge
    task wr(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] val);
        logic [31:0] d;
        logic a, e;
        ais_master_model_i.access(1'b1, idx, sub, {16'h0000, val}, d, a, e);
        check({31'h0, a}, 32'h0000_0001);
    endtask : wr

    // Present one sample pair, then allow the worst-case two-channel latency
    task sample(input logic [15:0] r1, input logic [15:0] r2);
        @(posedge core_clk);
        raw_in1 <= r1;
        raw_in2 <= r2;
        raw_valid <= 1'b1;
        @(posedge core_clk);
        raw_valid <= 1'b0;
        raw_in1 <= ~r1;
        raw_in2 <= ~r2;
        repeat (90) @(posedge core_clk);
        #1;
    endtask : sample

    task final_report;
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        // Defaults, voltage, current, then wide operands with truncation
        rows[0] = '{16'h04d2, 16'h0fff, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
                    16'h0001, 16'h0001, 32'h0000_04d2, 32'h0000_0fff};
        rows[1] = '{16'h03ff, 16'h0000, 16'hfe00, 16'hfe00, 16'h0014, 16'h0014,
                    16'h03ff, 16'h03ff, 32'h0000_0009, 32'hffff_fff6};
        rows[2] = '{16'h03ff, 16'h0200, 16'h0000, 16'h0000, 16'h0014, 16'h0014,
                    16'h03ff, 16'h03ff, 32'h0000_0014, 32'h0000_000a};
        rows[3] = '{16'hffff, 16'h0000, 16'h7fff, 16'h8000, 16'h7fff, 16'h7fff,
                    16'h0002, 16'h0003, 32'h5ffe_c001, 32'heaaa_d556};
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wr(`AIS_OBJ_OFFSET, `AIS_SUB_IN1, rows[i].off1);
            wr(`AIS_OBJ_OFFSET, `AIS_SUB_IN2, rows[i].off2);
            wr(`AIS_OBJ_MULT, `AIS_SUB_IN1, rows[i].num1);
            wr(`AIS_OBJ_MULT, `AIS_SUB_IN2, rows[i].num2);
            wr(`AIS_OBJ_DENOM, `AIS_SUB_IN1, rows[i].den1);
            wr(`AIS_OBJ_DENOM, `AIS_SUB_IN2, rows[i].den2);
            sample(rows[i].raw1, rows[i].raw2);
            check(in1_a, rows[i].exp1);
            check(in2_a, rows[i].exp2);
            check(in1_b, rows[i].exp1);
            check(in2_b, 32'h0000_0000);
            rd(`AIS_OBJ_READING, `AIS_SUB_IN1, rows[i].exp1, 1'b0);
        end
        // Settings read back sign-extended
        rd(`AIS_OBJ_OFFSET, `AIS_SUB_IN2, 32'hffff_8000, 1'b0);
        rd(`AIS_OBJ_DENOM, `AIS_SUB_IN2, 32'h0000_0003, 1'b0);
        // Writes to the reading and to a count are acknowledged and ignored
        wr(`AIS_OBJ_READING, `AIS_SUB_IN1, 16'h1234);
        rd(`AIS_OBJ_READING, `AIS_SUB_IN1, 32'h5ffe_c001, 1'b0);
        wr(`AIS_OBJ_MULT, `AIS_SUB_COUNT, 16'h0007);
        rd(`AIS_OBJ_MULT, `AIS_SUB_COUNT, 32'h0000_0002, 1'b0);
        // Unknown entries are refused, and input 2 is absent on one variant
        rd(16'h3324, `AIS_SUB_IN1, 32'h0000_0000, 1'b1);
        rd(`AIS_OBJ_OFFSET, 8'h03, 32'h0000_0000, 1'b1);
        rd(`AIS_OBJ_READING, `AIS_SUB_IN2, 32'heaaa_d556, 1'b0);
        check({31'h0, err_b}, 32'h0000_0001);
        check(rdata_b, 32'h0000_0000);
        // A zero divisor loaded against the rules leaves the reading held
        ais_master_model_i.allow_zero_den = 1'b1;
        wr(`AIS_OBJ_DENOM, `AIS_SUB_IN1, 16'h0000);
        sample(16'h0005, 16'h0005);
        check(in1_a, 32'h5ffe_c001);
        // Mid-run reset restores every entry of the table
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        check(in1_a, 32'h0000_0000);
        check(in2_a, 32'h0000_0000);
        for (int x = 0; x < 4; x++)
        begin
            for (int s = 0; s < 3; s++)
            begin
                rd(16'h3320 + x[15:0], s[7:0],
                   (s == 0) ? 32'h0000_0002 : ((x >= 2) ? 32'h0000_0001 : 32'h0), 1'b0);
            end
        end
        final_report();
    end
endmodule : testbench
